// ---- bench/trir_host.sv ----
// host model mastering the two-wire link
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ns
module trir_host
  import trir_pkg::*;
(
  input wire logic clk,
  input wire logic sdaWire,
  output logic scl,
  output logic sdaPullLow
);
  // --------
  // wire phases
  // --------
  // six clocks a phase keeps every edge well past the synchronisers
  localparam int HALF = 6;
  initial begin
    scl = 1'b1;
    sdaPullLow = 1'b0;
  end
  task automatic lines(input logic s, input logic d);
    scl <= s;
    sdaPullLow <= !d;
    repeat (HALF) @(posedge clk);
  endtask
  task automatic bitx(input logic d, output logic r);
    lines(1'b0, d);
    lines(1'b1, d);
    r = sdaWire;
    lines(1'b0, d);
  endtask
  task automatic start();
    lines(1'b1, 1'b1);
    lines(1'b1, 1'b0);
    lines(1'b0, 1'b0);
  endtask
  task automatic stop();
    lines(1'b0, 1'b0);
    lines(1'b1, 1'b0);
    lines(1'b1, 1'b1);
  endtask
  task automatic byteX(input logic [7:0] d, input logic ab, output logic [7:0] q, output logic r);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], b);
      q[i] = b;
    end
    bitx(ab, r);
  endtask
  task automatic xfer(input logic [6:0] dev, input logic [7:0] ptr, input logic rd, input logic [15:0] wd,
    output logic [15:0] q, output logic ack);
    logic [7:0] junk;
    logic [3:0] n;
    start();
    byteX({dev, 1'b0}, 1'b1, junk, n[0]);
    byteX(ptr, 1'b1, junk, n[1]);
    if (rd) begin
      start();
      byteX({dev, 1'b1}, 1'b1, junk, n[2]);
      byteX(8'hFF, 1'b0, q[15:8], n[3]);
      byteX(8'hFF, 1'b1, q[7:0], n[3]);
      n[3] = 1'b0;
    end else begin
      byteX(wd[15:8], 1'b1, junk, n[2]);
      byteX(wd[7:0], 1'b1, junk, n[3]);
      q = 16'h0000;
    end
    stop();
    ack = n == 4'h0;
  endtask
endmodule

// ---- bench/trir_regs_assertions.sv ----
// checker on the ports of the register block
// assumes binding to trir_regs, one clock, synchronous reset
`timescale 1ns/1ns
module trir_regs_checker
  import trir_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic sampleValid,
  input wire logic [11:0] sampleCode,
  input wire logic [15:0] upperLimit,
  input wire logic [15:0] lowerLimit,
  input wire logic [15:0] criticalLimit,
  input wire logic lockCritical,
  input wire logic lockWindow,
  input wire logic thermalEvent,
  input wire logic busTimeoutDisable,
  input wire logic busAlertDisable
);
  // --------
  // expected flags from the live inputs
  // --------
  logic signed [11:0] temp;
  logic anyFlag;
  assign temp = sampleCode;
  assign anyFlag = temp >= $signed({criticalLimit[12:2], 1'b0}) || temp > $signed({upperLimit[12:2], 1'b0})
    || temp < $signed({lowerLimit[12:2], 1'b0});
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  event_level_a: assert property (sampleValid |-> ##2 thermalEvent == $past(anyFlag, 2))
    else $error("event level wrong");
  event_hold_a: assert property (!$past(sampleValid, 2) |-> $stable(thermalEvent))
    else $error("event moved without sample");
  reset_clear_a: assert property ($fell(rst) |-> !thermalEvent && !sdaOe && !busTimeoutDisable && !busAlertDisable)
    else $error("outputs not cleared");
  lock_freeze_a: assert property ((lockCritical || lockWindow) [*5] |-> $stable({busTimeoutDisable, busAlertDisable}))
    else $error("config moved while locked");
  ack_edge_a: assert property ($changed(sdaOe) |-> !sclIn && !$past(sclIn))
    else $error("data moved with clock high");
  drain_only_a: assert property (sdaOut == 1'b0)
    else $error("data pin driven high");
  tmo_update_a: assert property ($changed(busTimeoutDisable) |-> !sclIn)
    else $error("timeout bit moved off a write");
  alert_update_a: assert property ($changed(busAlertDisable) |-> !sclIn)
    else $error("alert bit moved off a write");
endmodule
bind trir_regs trir_regs_checker chk_u (.clk, .rst, .sclIn, .sdaOut, .sdaOe, .sampleValid, .sampleCode, .upperLimit,
  .lowerLimit, .criticalLimit, .lockCritical, .lockWindow, .thermalEvent, .busTimeoutDisable, .busAlertDisable);

// ---- bench/trir_regs_tb.sv ----
// bench of the register block with a host model on the link
// assumes a pull-up on the data wire and the package pointer map
`timescale 1ns/1ns
module trir_regs_tb
  import trir_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sampleValid = 1'b0;
  logic [11:0] sampleCode = 12'h000;
  logic [15:0] upperLimit = 16'h0000;
  logic [15:0] lowerLimit = 16'h0000;
  logic [15:0] criticalLimit = 16'h0000;
  logic lockCritical = 1'b0;
  logic lockWindow = 1'b0;
  logic [2:0] addrPins = 3'h0;
  logic sclIn, sdaPullLow, sdaOe, sdaOut, sdaIn, thermalEvent, busTimeoutDisable, busAlertDisable, a;
  logic [15:0] w, lastExp, u, l, c;
  logic [11:0] code;
  logic [15:0] cfgIn [6] = '{16'hFFFF, 16'h0000, 16'h0000, 16'h0080, 16'h0001, 16'h0080};
  logic [15:0] cfgExp [6] = '{16'h0081, 16'h0081, 16'h0081, 16'h0080, 16'h0001, 16'h0001};
  logic [1:0] cfgLock [6] = '{2'h0, 2'h2, 2'h1, 2'h0, 2'h0, 2'h3};
  int errors = 0;
  int testsRun = 0;
  // a released wire floats high through the pull-up
  assign sdaIn = !((sdaOe && !sdaOut) || sdaPullLow);
  trir_regs dut_u (.clk, .rst, .sclIn, .sdaIn, .sdaOut, .sdaOe, .addrPins, .sampleValid, .sampleCode, .upperLimit,
    .lowerLimit, .criticalLimit, .lockCritical, .lockWindow, .thermalEvent, .busTimeoutDisable, .busAlertDisable);
  trir_host host_u (.clk(clk), .sdaWire(sdaIn), .scl(sclIn), .sdaPullLow(sdaPullLow));
  initial begin
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    give_verdict();
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", testsRun, errors);
    if (errors == 0 && testsRun > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic rd(input logic [7:0] ptr, input logic [15:0] exp, input string what);
    host_u.xfer({ADDR_HI_DEFAULT, addrPins}, ptr, 1'b1, 16'h0000, w, a);
    check(what, w, exp);
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [15:0] d);
    host_u.xfer({ADDR_HI_DEFAULT, addrPins}, ptr, 1'b0, d, w, a);
    check("write ack", {15'h0, a}, 16'h0001);
  endtask
  function automatic logic [15:0] expWord(input logic [11:0] t);
    logic signed [11:0] s;
    s = t;
    return {s >= $signed({criticalLimit[12:2], 1'b0}), s > $signed({upperLimit[12:2], 1'b0}),
      s < $signed({lowerLimit[12:2], 1'b0}), t, 1'b0};
  endfunction
  task automatic sample(input logic [11:0] t);
    sampleCode <= t;
    sampleValid <= 1'b1;
    @(posedge clk);
    sampleValid <= 1'b0;
    lastExp = expWord(t);
    repeat (3) @(posedge clk);
    check("event", {15'h0, thermalEvent}, {15'h0, |lastExp[15:13]});
    rd(PTR_TEMP, lastExp, "temp word");
  endtask
  initial begin
    void'($urandom(32'h622FF40E));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    addrPins <= $urandom;
    repeat (4) @(posedge clk);
    rd(PTR_TEMP, TEMP_RESET, "temp reset");
    rd(PTR_BUS_CFG, WORD_ZERO, "cfg reset");
    rd(PTR_MAKER_ID, MAKER_ID_DEFAULT, "maker id");
    rd(PTR_PART_ID, {PART_CODE_DEFAULT, REV_CODE_DEFAULT}, "part id");
    $display("test reset and id done");
    for (int i = 0; i < 8; i++) begin
      u = $urandom;
      l = $urandom;
      c = $urandom;
      code = $urandom;
      if (i == 3) begin
        u = 16'h0190;
        l = 16'h1F40;
        c = 16'h07D0;
      end
      code = i == 0 ? {c[12:2], 1'b0} : i == 1 ? {u[12:2], 1'b0} : i == 2 ? {l[12:2], 1'b0} : i == 3 ? 12'h0A0 : code;
      upperLimit <= u;
      lowerLimit <= l;
      criticalLimit <= c;
      sample(code);
    end
    wr(PTR_TEMP, 16'hFFFF);
    rd(PTR_TEMP, lastExp, "temp after write");
    $display("test samples done");
    for (int i = 0; i < 6; i++) begin
      lockCritical <= cfgLock[i][1];
      lockWindow <= cfgLock[i][0];
      wr(PTR_BUS_CFG, cfgIn[i]);
      rd(PTR_BUS_CFG, cfgExp[i], "cfg word");
      check("cfg pins", {14'h0, busTimeoutDisable, busAlertDisable}, {14'h0, cfgExp[i][7], cfgExp[i][0]});
    end
    $display("test config done");
    host_u.xfer({ADDR_HI_DEFAULT, ~addrPins}, PTR_TEMP, 1'b1, 16'h0000, w, a);
    check("foreign address ack", {15'h0, a}, 16'h0000);
    $display("test address done");
    // mid-run reset clears
    // leave a raised event and a set config bit behind so the reset has work to do
    lockCritical <= 1'b0;
    lockWindow <= 1'b0;
    criticalLimit <= WORD_ZERO;
    sample(12'h7FE);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    check("event after reset", {15'h0, thermalEvent}, 16'h0000);
    rd(PTR_TEMP, TEMP_RESET, "temp mid reset");
    rd(PTR_BUS_CFG, WORD_ZERO, "cfg mid reset");
    check("cfg pins after reset", {14'h0, busTimeoutDisable, busAlertDisable}, 16'h0000);
    $display("test mid reset done");
    give_verdict();
  end
endmodule

// ---- rtl/trir_compare.sv ----
// limit comparison and result word capture
// assumes sample strobe and limits come from logic on the same clock
`timescale 1ns/1ns
module trir_compare
  import trir_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sampleValid,
  input wire logic [11:0] sampleCode,
  input wire logic [15:0] upperLimit,
  input wire logic [15:0] lowerLimit,
  input wire logic [15:0] criticalLimit,
  output logic [15:0] resultWord,
  output logic eventLevel
);

  // ------------------------------------------------------------
  // comparison in eighth-degree steps
  // ------------------------------------------------------------
  logic signed [11:0] tempS;
  logic signed [11:0] upS;
  logic signed [11:0] lowS;
  logic signed [11:0] critS;
  logic critHit;
  logic aboveHit;
  logic belowHit;
  logic [15:0] resultWord_d;
  logic eventLevel_d;

  assign upS = $signed({upperLimit[LIM_MSB:LIM_LSB], 1'b0});
  assign lowS = $signed({lowerLimit[LIM_MSB:LIM_LSB], 1'b0});
  assign critS = $signed({criticalLimit[LIM_MSB:LIM_LSB], 1'b0});
  assign tempS = $signed(sampleCode);

  always_comb begin
    critHit = (tempS >= critS);
    aboveHit = (tempS > upS);
    belowHit = (tempS < lowS);
    resultWord_d = resultWord;
    eventLevel_d = eventLevel;
    if (sampleValid) begin
      resultWord_d[TEMP_CRIT_BIT] = critHit;
      resultWord_d[TEMP_ABOVE_BIT] = aboveHit;
      resultWord_d[TEMP_BELOW_BIT] = belowHit;
      resultWord_d[TEMP_SIGN_BIT:TEMP_VAL_LSB] = sampleCode;
      resultWord_d[0] = 1'b0;
      eventLevel_d = critHit | aboveHit | belowHit;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      resultWord <= TEMP_RESET;
      eventLevel <= 1'b0;
    end else begin
      resultWord <= resultWord_d;
      eventLevel <= eventLevel_d;
    end
  end

endmodule

// ---- rtl/trir_pkg.sv ----
// constants of the thermal read-back and identification register block
// assumes one 50 MHz system clock and a synchronous active-high reset
package trir_pkg;

  // ------------------------------------------------------------
  // register pointers
  // ------------------------------------------------------------
  localparam logic [7:0] PTR_BUS_CFG = 8'h00;
  localparam logic [7:0] PTR_TEMP = 8'h05;
  localparam logic [7:0] PTR_MAKER_ID = 8'h06;
  localparam logic [7:0] PTR_PART_ID = 8'h07;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int TEMP_CRIT_BIT = 15;
  localparam int TEMP_ABOVE_BIT = 14;
  localparam int TEMP_BELOW_BIT = 13;
  localparam int TEMP_SIGN_BIT = 12;
  localparam int TEMP_VAL_MSB = 11;
  localparam int TEMP_VAL_LSB = 1;
  localparam int LIM_MSB = 12;
  localparam int LIM_LSB = 2;
  localparam int CFG_TMO_BIT = 7;
  localparam int CFG_ALERT_BIT = 0;

  // ------------------------------------------------------------
  // reset values and link figures
  // ------------------------------------------------------------
  localparam logic [15:0] TEMP_RESET = 16'h0000;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // arbitrary neutral identification values
  localparam logic [15:0] MAKER_ID_DEFAULT = 16'h5A5A;
  localparam logic [7:0] PART_CODE_DEFAULT = 8'h42;
  localparam logic [7:0] REV_CODE_DEFAULT = 8'h01;
  localparam logic [3:0] ADDR_HI_DEFAULT = 4'h9;

  typedef enum logic [2:0] {
    LINK_IDLE,
    LINK_ADDR,
    LINK_ADDR_ACK,
    LINK_PTR,
    LINK_RX_ACK,
    LINK_WR,
    LINK_RD,
    LINK_RD_ACK
  } trir_link_e;

endpackage

// ---- rtl/trir_regs.sv ----
// two-wire slave with temperature, identification and bus config registers
// assumes the converter, limit registers and lock bits sit on the same clock;
// the two-wire pins and address straps are asynchronous and synchronised here
`timescale 1ns/1ns
module trir_regs
  import trir_pkg::*;
#(
  parameter logic [15:0] MAKER_ID = MAKER_ID_DEFAULT,
  parameter logic [7:0] PART_CODE = PART_CODE_DEFAULT,
  parameter logic [7:0] REV_CODE = REV_CODE_DEFAULT,
  parameter logic [3:0] ADDR_HI = ADDR_HI_DEFAULT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic [2:0] addrPins,
  input wire logic sampleValid,
  input wire logic [11:0] sampleCode,
  input wire logic [15:0] upperLimit,
  input wire logic [15:0] lowerLimit,
  input wire logic [15:0] criticalLimit,
  input wire logic lockCritical,
  input wire logic lockWindow,
  output logic thermalEvent,
  output logic busTimeoutDisable,
  output logic busAlertDisable
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [2:0] sclSync_q;
  logic [2:0] sdaSync_q;
  logic [2:0] addrS1_q;
  logic [2:0] addrS2_q;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic sdaNow;

  always_ff @(posedge clk) begin
    if (rst) begin
      sclSync_q <= 3'h7;
      sdaSync_q <= 3'h7;
      addrS1_q <= 3'h0;
      addrS2_q <= 3'h0;
    end else begin
      sclSync_q <= {sclSync_q[1:0], sclIn};
      sdaSync_q <= {sdaSync_q[1:0], sdaIn};
      addrS1_q <= addrPins;
      addrS2_q <= addrS1_q;
    end
  end

  // edges look only at the second and third stages
  assign sdaNow = sdaSync_q[1];
  assign sclRise = sclSync_q[1] & ~sclSync_q[2];
  assign sclFall = ~sclSync_q[1] & sclSync_q[2];
  assign startSeen = sclSync_q[1] & sclSync_q[2] & ~sdaSync_q[1] & sdaSync_q[2];
  assign stopSeen = sclSync_q[1] & sclSync_q[2] & sdaSync_q[1] & ~sdaSync_q[2];

  // ------------------------------------------------------------
  // result capture and event
  // ------------------------------------------------------------
  logic [15:0] resultWord;
  logic eventLevel;

  trir_compare u_compare (
    .clk(clk),
    .rst(rst),
    .sampleValid(sampleValid),
    .sampleCode(sampleCode),
    .upperLimit(upperLimit),
    .lowerLimit(lowerLimit),
    .criticalLimit(criticalLimit),
    .resultWord(resultWord),
    .eventLevel(eventLevel)
  );

  // ------------------------------------------------------------
  // link engine
  // ------------------------------------------------------------
  trir_link_e state_q, state_d;
  logic [3:0] bitCnt_q, bitCnt_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] ptr_q, ptr_d;
  logic [7:0] wrHi_q, wrHi_d;
  logic [15:0] rdWord_q, rdWord_d;
  logic byteIdx_q, byteIdx_d;
  logic isRead_q, isRead_d;
  logic sdaOe_q, sdaOe_d;
  logic tmoDis_q, tmoDis_d;
  logic alertDis_q, alertDis_d;
  logic event_q;
  logic [15:0] rdMux;
  logic [15:0] wrWord;
  logic [7:0] nextByte;

  // unmapped pointers read as zero
  always_comb begin
    unique case (ptr_q)
      PTR_TEMP: rdMux = resultWord;
      PTR_MAKER_ID: rdMux = MAKER_ID;
      PTR_PART_ID: rdMux = {PART_CODE, REV_CODE};
      PTR_BUS_CFG: begin
        rdMux = WORD_ZERO;
        rdMux[CFG_TMO_BIT] = tmoDis_q;
        rdMux[CFG_ALERT_BIT] = alertDis_q;
      end
      default: rdMux = WORD_ZERO;
    endcase
  end

  assign wrWord = {wrHi_q, shift_q};

  always_comb begin
    state_d = state_q;
    bitCnt_d = bitCnt_q;
    shift_d = shift_q;
    ptr_d = ptr_q;
    wrHi_d = wrHi_q;
    rdWord_d = rdWord_q;
    byteIdx_d = byteIdx_q;
    isRead_d = isRead_q;
    sdaOe_d = sdaOe_q;
    tmoDis_d = tmoDis_q;
    alertDis_d = alertDis_q;
    nextByte = byteIdx_q ? rdWord_q[15:8] : rdWord_q[7:0];
    // host starts and stops every transfer
    if (startSeen) begin
      state_d = LINK_ADDR;
      bitCnt_d = 4'h0;
      sdaOe_d = 1'b0;
    end else if (stopSeen) begin
      state_d = LINK_IDLE;
      sdaOe_d = 1'b0;
    end else begin
      unique case (state_q)
        LINK_IDLE: sdaOe_d = 1'b0;
        LINK_ADDR, LINK_PTR, LINK_WR: begin
          if (sclRise && bitCnt_q != BYTE_BITS) begin
            shift_d = {shift_q[6:0], sdaNow};
            bitCnt_d = bitCnt_q + 4'h1;
          end else if (sclFall && bitCnt_q == BYTE_BITS) begin
            bitCnt_d = 4'h0;
            sdaOe_d = 1'b1;
            if (state_q == LINK_ADDR) begin
              // only our own address is answered
              if (shift_q[7:1] == {ADDR_HI, addrS2_q}) begin
                isRead_d = shift_q[0];
                state_d = LINK_ADDR_ACK;
              end else begin
                sdaOe_d = 1'b0;
                state_d = LINK_IDLE;
              end
            end else if (state_q == LINK_PTR) begin
              ptr_d = shift_q;
              byteIdx_d = 1'b0;
              state_d = LINK_RX_ACK;
            end else begin
              state_d = LINK_RX_ACK;
              if (!byteIdx_q) begin
                wrHi_d = shift_q;
                byteIdx_d = 1'b1;
              end else begin
                byteIdx_d = 1'b0;
                if (ptr_q == PTR_BUS_CFG && !(lockCritical || lockWindow)) begin
                  tmoDis_d = wrWord[CFG_TMO_BIT];
                  alertDis_d = wrWord[CFG_ALERT_BIT];
                end
              end
            end
          end
        end
        LINK_ADDR_ACK: begin
          if (sclFall) begin
            if (isRead_q) begin
              // word is frozen at the address ack so both bytes match
              rdWord_d = rdMux;
              byteIdx_d = 1'b1;
              sdaOe_d = ~rdMux[15];
              bitCnt_d = 4'h1;
              state_d = LINK_RD;
            end else begin
              sdaOe_d = 1'b0;
              state_d = LINK_PTR;
            end
          end
        end
        LINK_RX_ACK: begin
          if (sclFall) begin
            sdaOe_d = 1'b0;
            state_d = LINK_WR;
          end
        end
        LINK_RD: begin
          if (sclFall) begin
            if (bitCnt_q == BYTE_BITS) begin
              sdaOe_d = 1'b0;
              state_d = LINK_RD_ACK;
            end else begin
              sdaOe_d = ~nextByte[3'(4'h7 - bitCnt_q)];
              bitCnt_d = bitCnt_q + 4'h1;
            end
          end
        end
        LINK_RD_ACK: begin
          if (sclRise && sdaNow) begin
            state_d = LINK_IDLE;
          end else if (sclFall) begin
            // further bytes re-read the pointed register, high then low
            byteIdx_d = ~byteIdx_q;
            if (byteIdx_q) begin
              sdaOe_d = ~rdWord_q[7];
            end else begin
              rdWord_d = rdMux;
              sdaOe_d = ~rdMux[15];
            end
            bitCnt_d = 4'h1;
            state_d = LINK_RD;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= LINK_IDLE;
      bitCnt_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      wrHi_q <= 8'h00;
      rdWord_q <= WORD_ZERO;
      byteIdx_q <= 1'b0;
      isRead_q <= 1'b0;
      sdaOe_q <= 1'b0;
      tmoDis_q <= 1'b0;
      alertDis_q <= 1'b0;
      event_q <= 1'b0;
    end else begin
      state_q <= state_d;
      bitCnt_q <= bitCnt_d;
      shift_q <= shift_d;
      ptr_q <= ptr_d;
      wrHi_q <= wrHi_d;
      rdWord_q <= rdWord_d;
      byteIdx_q <= byteIdx_d;
      isRead_q <= isRead_d;
      sdaOe_q <= sdaOe_d;
      tmoDis_q <= tmoDis_d;
      alertDis_q <= alertDis_d;
      event_q <= eventLevel;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // open drain: the pad only ever pulls low
  assign sdaOut = 1'b0;
  assign sdaOe = sdaOe_q;
  assign thermalEvent = event_q;
  assign busTimeoutDisable = tmoDis_q;
  assign busAlertDisable = alertDis_q;

endmodule
